// [verilog/clk_pwr_pkg.sv]
package clk_pwr_pkg;
   // io port decode
   localparam logic [15:0] IO_INDEX_PORT = 16'h03D6;
   localparam logic [15:0] IO_DATA_PORT = 16'h03D7;
   // register indexes
   localparam logic [7:0] IDX_CLK_SRC = 8'hCF;
   localparam logic [7:0] IDX_PWRDN = 8'hD0;
   localparam logic [7:0] IDX_PWRCONS = 8'hD1;
   localparam logic [7:0] IDX_SLOWCNT = 8'hD2;
   localparam logic [7:0] IDX_SCRATCH_FIRST = 8'hE0;
   localparam logic [7:0] IDX_SCRATCH_LAST = 8'hEB;
   localparam logic [7:0] IDX_TEST_FIRST = 8'hF8;
   localparam logic [7:0] IDX_TEST_LAST = 8'hFC;
   localparam int SCRATCH_COUNT = 12;
   localparam int TEST_COUNT = 5;
   // clock source fields
   localparam int BIT_SEQ_CLK = 3;
   localparam int BIT_DOT_SRC = 2;
   localparam int BIT_MEM_SRC = 1;
   localparam logic [7:0] CLK_SRC_MASK = 8'h0E;
   // powerdown fields
   localparam int BIT_VPORT = 6;
   localparam int BIT_CAPTURE = 5;
   localparam int BIT_PLAYBACK = 4;
   localparam int BIT_MVCO = 3;
   localparam int BIT_DVCO = 2;
   localparam int BIT_PALETTE = 1;
   localparam int BIT_DAC = 0;
   localparam logic [7:0] PWRDN_MASK = 8'h7F;
   localparam logic [7:0] PWRDN_RESET = 8'h3F;
   // power conservation fields
   localparam int BIT_BLT_IDLE_PD = 0;
   localparam logic [7:0] PWRCONS_MASK = 8'h3F;
   localparam logic [7:0] PWRCONS_RESET = 8'h00;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   localparam logic [7:0] TEST_RESET = 8'h00;
   // strap bit position in configuration pins register
   localparam int BIT_STRAP_STATUS = 4;
   // reference clock divisors
   localparam int REF_DIV_DOT0 = 4;
   localparam int REF_DIV_SEQ = 384;
   // 2 kHz tick from 14.318 MHz reference: 14318000 / 2000
   localparam int REF_FREQ_HZ = 14318000;
   localparam int SLOW_TICK_HZ = 2000;
   localparam int SLOW_DIV = REF_FREQ_HZ / SLOW_TICK_HZ;
endpackage

// [verilog/scratch_mem.sv]
`timescale 1ns/1ps
module scratch_mem #(
   parameter int DEPTH = 12,
   parameter int AW = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [AW-1:0] rdAddr,
   output logic [7:0] rdData
);
   import clk_pwr_pkg::*;
   logic [7:0] mem [DEPTH];

   // storage words, reset to zero
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= SCRATCH_RESET;
         end
      end else if (wrEn && (int'(wrAddr) < DEPTH)) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= 8'h00;
      end else if (int'(rdAddr) < DEPTH) begin
         rdData <= mem[rdAddr];
      end else begin
         rdData <= 8'h00;
      end
   end
endmodule

// [verilog/clock_source_power_control.sv]
`timescale 1ns/1ps
// Function
// - reference divisor bit 0 divides dot clock 0 reference by 4, else none
// - sequencing select 0 times panel steps with reference divided by 384
// - sequencing select 1 times panel steps from the 32 kHz pin clock
// - dot source 0 uses external dot clock, disables three synthesizers
// - dot and memory source bits reset to strap; strap readable read-only
// - memory source 0 disables memory synthesizer, uses reference pin clock
// - reserved clock source bits and powerdown bit 7 read zero
// - powerdown bit 6 gates video port, resets to 0
// - bits 5 and 4 enable capture and playback, reset to 1
// - bits 3 and 2 enable memory and dot clock VCOs, reset to 1
// - bits 1 and 0 enable palette and converters, reset to 1
// - conservation bit 0 powers down idle blit engine automatically
// - blit idle power-down invisible: registers and behaviour unchanged
// - readable 8-bit counter decrements at 2 kHz from reference and wraps
// - scratch flag registers E0h-EBh are plain storage with no effect
// - index written at 3D6h, data accessed at 3D7h
module clock_source_power_control (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioWrData,
   output logic [7:0] ioRdData,
   output logic ioRdValid,
   input wire logic clock_source_strap_pin,
   input wire logic reference_clock_pin,
   input wire logic external_dot_clock_pin,
   input wire logic slow_clock_input_pin,
   input wire logic bltBusy,
   output logic dot0RefDivide,
   output logic seqClkTick,
   output logic seqClkFromPin,
   output logic [2:0] dotSynthEnable,
   output logic dotClockFromPin,
   output logic memSynthEnable,
   output logic memClockFromPin,
   output logic videoPortEnable,
   output logic captureEnable,
   output logic playbackEnable,
   output logic memVcoEnable,
   output logic dotVcoEnable,
   output logic paletteEnable,
   output logic dacEnable,
   output logic bltPowerDown,
   output logic config_strap_status_reg,
   input wire logic dot0RefDivSel
);
   import clk_pwr_pkg::*;

   function automatic logic inRange(input logic [7:0] idx,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
      inRange = (idx >= lo) && (idx <= hi);
   endfunction
   logic [7:0] indexReg;
   logic [7:0] clock_source_select_reg;
   logic [7:0] powerdown_control_reg;
   logic [7:0] power_conservation_reg;
   logic [7:0] slow_down_counter_reg;
   logic [7:0] chip_test_regs [TEST_COUNT];
   logic strapCaught;
   logic inReset;
   logic [2:0] refSync;
   logic [2:0] slowSync;
   logic refLevel;
   logic refLevelPrev;
   logic slowLevel;
   logic slowLevelPrev;
   logic refRise;
   logic slowRise;
   logic [8:0] seqDiv;
   logic [15:0] slowDiv;
   logic slowTick;
   logic [2:0] dot0Div;
   logic indexWrite;
   logic dataWrite;
   logic dataRead;
   logic scratchWr;
   logic [3:0] scratchWrAddr;
   logic [3:0] scratchRdAddr;
   logic [7:0] scratchRdData;
   logic readPending;
   logic readScratch;
   logic [7:0] readHeld;
   logic [7:0] next_readValue;
   // io decode of the indexed pair
   assign indexWrite = ioWrite && (ioAddr == IO_INDEX_PORT);
   assign dataWrite = ioWrite && (ioAddr == IO_DATA_PORT);
   assign dataRead = ioRead && (ioAddr == IO_DATA_PORT);

   // index register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         indexReg <= 8'h00;
      end else if (indexWrite) begin
         indexReg <= ioWrData;
      end
   end

   // three-flop synchronisers for the reference and slow pin clocks
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         refSync <= 3'h0;
         slowSync <= 3'h0;
      end else begin
         refSync <= {refSync[1:0], reference_clock_pin};
         slowSync <= {slowSync[1:0], slow_clock_input_pin};
      end
   end

   // filtered levels change only when the second and third agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         refLevel <= 1'b0;
         refLevelPrev <= 1'b0;
         slowLevel <= 1'b0;
         slowLevelPrev <= 1'b0;
      end else begin
         if (refSync[1] == refSync[2]) begin
            refLevel <= refSync[2];
         end
         if (slowSync[1] == slowSync[2]) begin
            slowLevel <= slowSync[2];
         end
         refLevelPrev <= refLevel;
         slowLevelPrev <= slowLevel;
      end
   end
   // one-cycle rise strobes of the filtered levels
   assign refRise = refLevel && !refLevelPrev;
   assign slowRise = slowLevel && !slowLevelPrev;
   // strap caught on the first clock after reset release
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         inReset <= 1'b1;
         strapCaught <= 1'b0;
      end else begin
         inReset <= 1'b0;
         if (inReset) begin
            strapCaught <= clock_source_strap_pin;
         end
      end
   end
   assign config_strap_status_reg = strapCaught;
   // clock source select register, source bits follow strap after reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_source_select_reg <= 8'h00;
      end else if (inReset) begin
         clock_source_select_reg[BIT_DOT_SRC] <= clock_source_strap_pin;
         clock_source_select_reg[BIT_MEM_SRC] <= clock_source_strap_pin;
      end else if (dataWrite && indexReg == IDX_CLK_SRC) begin
         clock_source_select_reg <= ioWrData & CLK_SRC_MASK;
      end
   end

   // powerdown control register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         powerdown_control_reg <= PWRDN_RESET;
      end else if (dataWrite && indexReg == IDX_PWRDN) begin
         powerdown_control_reg <= ioWrData & PWRDN_MASK;
      end
   end

   // power conservation register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_conservation_reg <= PWRCONS_RESET;
      end else if (dataWrite && indexReg == IDX_PWRCONS) begin
         power_conservation_reg <= ioWrData & PWRCONS_MASK;
      end
   end

   // test registers, kept as storage only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < TEST_COUNT; i++) begin
            chip_test_regs[i] <= TEST_RESET;
         end
      end else if (dataWrite &&
                   inRange(indexReg, IDX_TEST_FIRST, IDX_TEST_LAST)) begin
         chip_test_regs[3'(indexReg - IDX_TEST_FIRST)] <= ioWrData;
      end
   end

   // 2 kHz prescaler counting reference edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         slowDiv <= 16'h0000;
         slowTick <= 1'b0;
      end else begin
         slowTick <= 1'b0;
         if (refRise) begin
            if (slowDiv == 16'(SLOW_DIV - 1)) begin
               slowDiv <= 16'h0000;
               slowTick <= 1'b1;
            end else begin
               slowDiv <= slowDiv + 16'h0001;
            end
         end
      end
   end

   // looping down counter, a write loads a new value
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_down_counter_reg <= 8'h00;
      end else if (dataWrite && indexReg == IDX_SLOWCNT) begin
         slow_down_counter_reg <= ioWrData;
      end else if (slowTick) begin
         slow_down_counter_reg <= slow_down_counter_reg - 8'h01;
      end
   end
   // panel sequencing time base: reference / 384 or pin clock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seqDiv <= 9'h000;
         seqClkTick <= 1'b0;
      end else begin
         seqClkTick <= 1'b0;
         if (clock_source_select_reg[BIT_SEQ_CLK]) begin
            seqDiv <= 9'h000;
            seqClkTick <= slowRise;
         end else if (refRise) begin
            if (seqDiv == 9'(REF_DIV_SEQ - 1)) begin
               seqDiv <= 9'h000;
               seqClkTick <= 1'b1;
            end else begin
               seqDiv <= seqDiv + 9'h001;
            end
         end
      end
   end
   assign seqClkFromPin = clock_source_select_reg[BIT_SEQ_CLK];
   // dot clock 0 reference predivider, strobe per divided edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dot0Div <= 3'h0;
         dot0RefDivide <= 1'b0;
      end else begin
         dot0RefDivide <= 1'b0;
         if (refRise) begin
            if (dot0RefDivSel) begin
               dot0Div <= 3'h0;
               dot0RefDivide <= 1'b1;
            end else if (dot0Div == 3'(REF_DIV_DOT0 - 1)) begin
               dot0Div <= 3'h0;
               dot0RefDivide <= 1'b1;
            end else begin
               dot0Div <= dot0Div + 3'h1;
            end
         end
      end
   end
   // clock source steering
   assign dotSynthEnable = {3{clock_source_select_reg[BIT_DOT_SRC]}};
   assign dotClockFromPin = !clock_source_select_reg[BIT_DOT_SRC];
   assign memSynthEnable = clock_source_select_reg[BIT_MEM_SRC];
   assign memClockFromPin = !clock_source_select_reg[BIT_MEM_SRC];

   // powerdown enables
   assign videoPortEnable = powerdown_control_reg[BIT_VPORT];
   assign captureEnable = powerdown_control_reg[BIT_CAPTURE];
   assign playbackEnable = powerdown_control_reg[BIT_PLAYBACK];
   assign memVcoEnable = powerdown_control_reg[BIT_MVCO];
   assign dotVcoEnable = powerdown_control_reg[BIT_DVCO];
   assign paletteEnable = powerdown_control_reg[BIT_PALETTE];
   assign dacEnable = powerdown_control_reg[BIT_DAC];

   // blit gating only while idle, so register access is untouched
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bltPowerDown <= 1'b0;
      end else begin
         bltPowerDown <= power_conservation_reg[BIT_BLT_IDLE_PD]
                         && !bltBusy;
      end
   end

   // scratch flag storage
   assign scratchWr = dataWrite &&
      inRange(indexReg, IDX_SCRATCH_FIRST, IDX_SCRATCH_LAST);
   assign scratchWrAddr = 4'(indexReg - IDX_SCRATCH_FIRST);
   assign scratchRdAddr = 4'(indexReg - IDX_SCRATCH_FIRST);

   scratch_mem #(
      .DEPTH(SCRATCH_COUNT),
      .AW(4)
   ) u_scratch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wrEn(scratchWr),
      .wrAddr(scratchWrAddr),
      .wrData(ioWrData),
      .rdAddr(scratchRdAddr),
      .rdData(scratchRdData)
   );

   // read multiplexer for non-scratch registers
   always_comb begin
      next_readValue = 8'h00;
      if (indexReg == IDX_CLK_SRC) begin
         next_readValue = clock_source_select_reg & CLK_SRC_MASK;
      end else if (indexReg == IDX_PWRDN) begin
         next_readValue = powerdown_control_reg & PWRDN_MASK;
      end else if (indexReg == IDX_PWRCONS) begin
         next_readValue = power_conservation_reg;
      end else if (indexReg == IDX_SLOWCNT) begin
         next_readValue = slow_down_counter_reg;
      end else if (inRange(indexReg, IDX_TEST_FIRST, IDX_TEST_LAST)) begin
         next_readValue = chip_test_regs[3'(indexReg - IDX_TEST_FIRST)];
      end
   end

   // read answer one cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         readPending <= 1'b0;
         readScratch <= 1'b0;
         readHeld <= 8'h00;
      end else begin
         readPending <= dataRead;
         if (dataRead) begin
            readScratch <= inRange(indexReg, IDX_SCRATCH_FIRST,
                                   IDX_SCRATCH_LAST);
            readHeld <= next_readValue;
         end
      end
   end
   // answer strobe and data steering
   assign ioRdValid = readPending;
   assign ioRdData = readScratch ? scratchRdData : readHeld;
endmodule

// [tb/clock_power_monitor.sv]
`timescale 1ns/1ps
module clock_power_monitor
   import clk_pwr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioWrData,
   input wire logic [7:0] ioRdData,
   input wire logic ioRdValid,
   input wire logic clock_source_strap_pin,
   input wire logic bltBusy,
   input wire logic seqClkFromPin,
   input wire logic [2:0] dotSynthEnable,
   input wire logic dotClockFromPin,
   input wire logic memSynthEnable,
   input wire logic memClockFromPin,
   input wire logic videoPortEnable,
   input wire logic bltPowerDown,
   input wire logic config_strap_status_reg
);
   logic [7:0] curIdx;
   logic [7:0] rdIdx;
   // shadow of the index register and the index of the last data read
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         curIdx <= 8'h00;
         rdIdx <= 8'h00;
      end else begin
         if (ioWrite && ioAddr == IO_INDEX_PORT) curIdx <= ioWrData;
         if (ioRead && ioAddr == IO_DATA_PORT) rdIdx <= curIdx;
      end
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   a_read_answer: assert property (
      ioRead && ioAddr == IO_DATA_PORT |=> ioRdValid)
      else $error("data read got no valid strobe");
   a_valid_cause: assert property (
      ioRdValid |-> $past(ioRead) && $past(ioAddr) == IO_DATA_PORT)
      else $error("valid strobe without a read");
   a_clk_src_read: assert property (
      ioRdValid && rdIdx == IDX_CLK_SRC |->
      (ioRdData & ~CLK_SRC_MASK) == 8'h00 &&
      ioRdData[BIT_DOT_SRC] == !dotClockFromPin &&
      ioRdData[BIT_MEM_SRC] == memSynthEnable &&
      ioRdData[BIT_SEQ_CLK] == seqClkFromPin)
      else $error("clock source read disagrees with outputs");
   a_pwrdn_read: assert property (
      ioRdValid && rdIdx == IDX_PWRDN |->
      !ioRdData[7] && ioRdData[BIT_VPORT] == videoPortEnable)
      else $error("powerdown read disagrees with outputs");
   a_dot_synth: assert property (
      dotSynthEnable == {3{!dotClockFromPin}})
      else $error("dot synthesizers disagree with source");
   a_mem_synth: assert property (
      memSynthEnable != memClockFromPin)
      else $error("memory synthesizer disagrees with source");
   a_blt_idle: assert property (
      bltPowerDown |-> !$past(bltBusy))
      else $error("blit engine powered down while busy");
   a_strap_load: assert property (
      $rose(rst_n) |=> config_strap_status_reg ==
      $past(clock_source_strap_pin) &&
      dotClockFromPin == !$past(clock_source_strap_pin))
      else $error("strap level not loaded after reset");
   a_scratch_inert: assert property (
      ioWrite && ioAddr == IO_DATA_PORT && curIdx >= IDX_SCRATCH_FIRST &&
      curIdx <= IDX_SCRATCH_LAST |=> $stable({videoPortEnable,
      dotClockFromPin, memClockFromPin, seqClkFromPin}))
      else $error("scratch write changed a control output");
endmodule

bind clock_source_power_control clock_power_monitor u_clock_power_monitor (
   .core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr),
   .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData),
   .ioRdData(ioRdData), .ioRdValid(ioRdValid),
   .clock_source_strap_pin(clock_source_strap_pin), .bltBusy(bltBusy),
   .seqClkFromPin(seqClkFromPin), .dotSynthEnable(dotSynthEnable),
   .dotClockFromPin(dotClockFromPin), .memSynthEnable(memSynthEnable),
   .memClockFromPin(memClockFromPin), .videoPortEnable(videoPortEnable),
   .bltPowerDown(bltPowerDown),
   .config_strap_status_reg(config_strap_status_reg)
);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   import clk_pwr_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] ioAddr = 16'h0000;
   logic ioWrite = 1'b0;
   logic ioRead = 1'b0;
   logic [7:0] ioWrData = 8'h00;
   logic strapPin = 1'b0;
   logic refPin = 1'b0;
   logic slowPin = 1'b0;
   logic bltBusy = 1'b0;
   logic divSel = 1'b0;
   logic [7:0] ioRdData, v, p, o;
   logic [7:0] mem [12];
   logic ioRdValid, divTick, seqTick, seqPin, dotPin, memSyn, memPin;
   logic vport, capt, play, mvco, dvco, pal, dac, bltPd, strapStat;
   logic [2:0] dotSyn;
   int n_errors = 0;
   int num_checks = 0;
   int seed = 86165;
   int nDiv = 0;
   int nSeq = 0;
   int c;
   always #5 core_clk = ~core_clk;
   // count divided reference and sequencing pulses
   always @(posedge core_clk) begin
      if (divTick === 1'b1) nDiv <= nDiv + 1;
      if (seqTick === 1'b1) nSeq <= nSeq + 1;
   end
   clock_source_power_control u_clock_source_power_control (
      .core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData),
      .ioRdData(ioRdData), .ioRdValid(ioRdValid),
      .clock_source_strap_pin(strapPin), .reference_clock_pin(refPin),
      .external_dot_clock_pin(1'b0), .slow_clock_input_pin(slowPin),
      .bltBusy(bltBusy), .dot0RefDivide(divTick), .seqClkTick(seqTick),
      .seqClkFromPin(seqPin), .dotSynthEnable(dotSyn),
      .dotClockFromPin(dotPin), .memSynthEnable(memSyn),
      .memClockFromPin(memPin), .videoPortEnable(vport),
      .captureEnable(capt), .playbackEnable(play), .memVcoEnable(mvco),
      .dotVcoEnable(dvco), .paletteEnable(pal), .dacEnable(dac),
      .bltPowerDown(bltPd), .config_strap_status_reg(strapStat),
      .dot0RefDivSel(divSel)
   );
   // expected output pattern of the clock source bits
   function automatic logic [6:0] srcExp(input logic [7:0] w);
      return {~w[2], {3{w[2]}}, ~w[1], w[1], w[3]};
   endfunction
   task check(input string name, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", name, e, g);
         n_errors++;
      end
   endtask
   task ioWr(input logic [15:0] a, input logic [7:0] d);
      @(negedge core_clk);
      ioAddr = a;
      ioWrData = d;
      ioWrite = 1'b1;
      @(negedge core_clk);
      ioWrite = 1'b0;
   endtask
   task regWr(input logic [7:0] idx, input logic [7:0] d);
      ioWr(IO_INDEX_PORT, idx);
      ioWr(IO_DATA_PORT, d);
   endtask
   task regChk(input string name, input logic [7:0] idx, input logic [7:0] e);
      int i;
      ioWr(IO_INDEX_PORT, idx);
      @(negedge core_clk);
      ioAddr = IO_DATA_PORT;
      ioRead = 1'b1;
      @(negedge core_clk);
      ioRead = 1'b0;
      for (i = 0; i < 3 && ioRdValid !== 1'b1; i++) @(negedge core_clk);
      check("read valid", 16'h0001, {15'h0000, ioRdValid});
      check(name, e, ioRdData);
   endtask
   // slow edges on the reference pin or the 32 kHz pin
   task pinRise(input int n, input logic slow);
      repeat (n) begin
         repeat (4) @(negedge core_clk);
         if (slow) begin
            slowPin = 1'b1;
         end else begin
            refPin = 1'b1;
         end
         repeat (4) @(negedge core_clk);
         slowPin = 1'b0;
         refPin = 1'b0;
      end
      repeat (8) @(negedge core_clk);
   endtask
   task summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #800000;
      $display("mismatch watchdog expected done seen hang");
      n_errors++;
      summarize();
   end
   // reset for five cycles, then read back the reset state
   task resetChk;
      rst_n = 1'b0;
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      v = {5'h00, {2{strapPin}}, 1'b0};
      regChk("clk src reset", IDX_CLK_SRC, v);
      check("strap status", strapPin, strapStat);
      regChk("pwrdn reset", IDX_PWRDN, PWRDN_RESET);
      regChk("cons reset", IDX_PWRCONS, PWRCONS_RESET);
   endtask
   initial begin
      v = 8'($random(seed));
      strapPin = v[0];
      resetChk();
      for (c = 0; c < 10; c++) begin
         v = (c == 0) ? 8'hFF : (c == 1) ? 8'h00 : 8'($random(seed));
         p = (c == 0) ? 8'hFF : (c == 1) ? 8'h00 : 8'($random(seed));
         regWr(IDX_CLK_SRC, v);
         regWr(IDX_PWRDN, p);
         regChk("clk src", IDX_CLK_SRC, v & CLK_SRC_MASK);
         o = {1'b0, dotPin, dotSyn, memPin, memSyn, seqPin};
         check("src outs", srcExp(v), o);
         regChk("pwrdn", IDX_PWRDN, p & PWRDN_MASK);
         o = {1'b0, vport, capt, play, mvco, dvco, pal, dac};
         check("enables", p & PWRDN_MASK, o);
      end
      for (c = 1; c >= 0; c--) begin
         regWr(IDX_PWRCONS, {7'h00, c[0]});
         repeat (6) begin
            v = 8'($random(seed));
            bltBusy = v[0];
            repeat (2) @(negedge core_clk);
            check("blt pd", c[0] & ~v[0], bltPd);
         end
         regChk("pwrdn in pd", IDX_PWRDN, p & PWRDN_MASK);
      end
      for (c = 0; c < 12; c++) begin
         mem[c] = 8'($random(seed));
         regWr(IDX_SCRATCH_FIRST + 8'(c), mem[c]);
      end
      for (c = 0; c < 12; c++) begin
         regChk("scratch", IDX_SCRATCH_FIRST + 8'(c), mem[c]);
      end
      regWr(8'h10, 8'hA5);
      regChk("unmapped", 8'h10, 8'h00);
      for (c = 0; c < 5; c++) begin
         regChk("test reg", IDX_TEST_FIRST + 8'(c), TEST_RESET);
      end
      regWr(IDX_CLK_SRC, 8'h06);
      regWr(IDX_SLOWCNT, 8'h00);
      nDiv = 0;
      nSeq = 0;
      pinRise(SLOW_DIV, 1'b0);
      regChk("counter", IDX_SLOWCNT, 8'hFF);
      check("div4 pulses", SLOW_DIV / REF_DIV_DOT0, nDiv);
      check("seq pulses", SLOW_DIV / REF_DIV_SEQ, nSeq);
      divSel = 1'b1;
      nDiv = 0;
      pinRise(8, 1'b0);
      check("div1 pulses", 16'd8, nDiv);
      regWr(IDX_CLK_SRC, 8'h0E);
      nSeq = 0;
      pinRise(5, 1'b1);
      check("pin seq pulses", 16'd5, nSeq);
      // second reset mid-run with the other strap level
      strapPin = ~strapPin;
      resetChk();
      summarize();
   end
endmodule
